// ---- lsch_pkg.sv ----
// lsch_pkg: constants, types and register map of the link setup command handler.
// assumes a 25 MHz pclk and an APB3 master with 8-bit byte addresses.
package lsch_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CMD       = 8'h00;
  localparam logic [7:0] OFF_EVT       = 8'h04;
  localparam logic [7:0] OFF_CFG_INTV  = 8'h08;
  localparam logic [7:0] OFF_CFG_LATTO = 8'h0C;
  localparam logic [7:0] OFF_CTRL      = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_RPT_INTV  = 8'h18;
  localparam logic [7:0] OFF_RPT_LATTO = 8'h1C;

  // command codes and length bytes
  localparam logic [7:0] CODE_BOND    = 8'h10;
  localparam logic [7:0] CODE_TERM    = 8'h11;
  localparam logic [7:0] CODE_UPD     = 8'h13;
  localparam logic [7:0] LEN_BOND     = 8'h05;
  localparam logic [7:0] LEN_TERM     = 8'h02;
  localparam logic [7:0] LEN_UPD_DEF  = 8'h01;
  localparam logic [7:0] LEN_UPD_FULL = 8'h09;
  localparam logic [7:0] LEN_MAX      = 8'h09;

  // accepted field ranges
  localparam logic [15:0] DUR_MIN  = 16'h0001;
  localparam logic [15:0] DUR_MAX  = 16'h001E;
  localparam logic [15:0] PER_MIN  = 16'h0020;
  localparam logic [15:0] PER_MAX  = 16'h4000;
  localparam logic [7:0]  RSN_USER = 8'h01;
  localparam logic [7:0]  RSN_TIME = 8'h02;
  localparam logic [15:0] INTV_MIN = 16'h0006;
  localparam logic [15:0] INTV_MAX = 16'h0C80;
  localparam logic [15:0] LAT_MAX  = 16'h03E8;
  localparam logic [15:0] TO_MIN   = 16'h000A;
  localparam logic [15:0] TO_MAX   = 16'h0C80;

  // acknowledgement status codes
  localparam logic [7:0] ST_OK  = 8'h00;
  localparam logic [7:0] ST_ERR = 8'h01;

  // timing: one second of advertising in pclk cycles
  localparam int unsigned SEC_NS      = 1000000000;
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_NS;

  // pending radio event bit positions
  localparam int P_UP = 0;
  localparam int P_LOST = 1;
  localparam int P_BOND = 2;
  localparam int P_TIM = 3;
  localparam int P_ADVTO = 4;

  // connection parameters: min in the low half-word
  typedef struct packed {
    logic [15:0] tmo;
    logic [15:0] lat;
    logic [15:0] max;
    logic [15:0] min;
  } lsch_timing_t;

  localparam lsch_timing_t CFG_RST = 64'h0190_0000_0028_0018;

  typedef enum logic [2:0] {
    EV_NONE  = 3'b000,
    EV_ACK   = 3'b001,
    EV_UP    = 3'b010,
    EV_PAIR  = 3'b011,
    EV_DOWN  = 3'b100,
    EV_TIMING = 3'b101
  } lsch_evt_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_BOND   = 3'b010,
    S_PAIR   = 3'b011,
    S_TERM   = 3'b100,
    S_TIMING = 3'b101
  } lsch_state_t;

endpackage : lsch_pkg

// ---- lsch_link_setup_cmd.sv ----
// lsch_link_setup_cmd: interprets bonding, termination and timing-change commands.
// assumes an APB3 master on pclk and a radio link layer on the same clock.
// Operation
// - bonding is code 0x10, length 5, duration then period fields.
// - bonding duration must be 1 to 30 seconds.
// - when duration expires, advertising stops and device returns to standby.
// - period is LSB first, 0.625 ms units, 0x0020 to 0x4000.
// - bonding success emits ack, link up, pairing result in order.
// - bonding failure emits ack, optional link up, then link down.
// - termination is code 0x11, length 2, one reason byte.
// - reason 0x01 is user termination, 0x02 unacceptable timing.
// - accepted termination emits ack then link down.
// - timing change is code 0x13 and requests a peer parameter update.
// - timing change length is exactly 1 or exactly 9.
// - with no parameters the configured timing values are requested.
// - with parameters all four supplied values are requested instead.
// - order is min, max, latency, timeout, each two bytes LSB first.
// - min and max intervals count units of 1.25 ms.
// - latency counts skippable connection events, 0x0000 to 0x03E8.
// - supervision timeout counts units of 10 ms.
// - timing change emits ack first, then timing report.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module lsch_link_setup_cmd #(
  parameter int unsigned CYC_PER_SEC = lsch_pkg::CYC_PER_SEC
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // radio link layer events
  input  wire logic                  rf_link_up,
  input  wire logic                  rf_link_lost,
  input  wire logic                  rf_bond_ok,
  input  wire logic                  rf_timing_rpt,
  input  wire lsch_pkg::lsch_timing_t rf_timing,
  // radio link layer requests
  output logic                       adv_en,
  output logic      [15:0]           adv_period,
  output logic                       term_req,
  output logic      [7:0]            term_reason,
  output logic                       upd_req,
  output lsch_pkg::lsch_timing_t     upd_prm
);

  lsch_pkg::lsch_state_t  state_r;
  lsch_pkg::lsch_state_t  state_nxt;
  lsch_pkg::lsch_evt_t    evt_type_r;
  lsch_pkg::lsch_evt_t    push_type;
  lsch_pkg::lsch_timing_t cfg_r;
  lsch_pkg::lsch_timing_t rpt_r;
  logic [7:0]  cmd_buf_r [10];
  logic [3:0]  idx_r;
  logic        exec_r;
  logic        evt_valid_r;
  logic [7:0]  evt_code_r;
  logic [7:0]  evt_stat_r;
  logic [4:0]  pend_r;
  logic [4:0]  pend_clr;
  logic [4:0]  pend_set;
  logic        linked_r;
  logic        cfg_done_r;
  logic [31:0] prescale_r;
  logic [4:0]  secs_r;
  logic        tmr_expire;
  logic        push;
  logic [7:0]  push_stat;
  logic        start_bond;
  logic        start_term;
  logic        start_upd;
  logic        cmd_ok;
  logic        acc;
  logic        do_x;
  logic        wr_cmd;
  logic        cmd_refuse;
  logic        rd_err;
  logic [31:0] rd_mux;
  logic [7:0]  len;
  logic [7:0]  code;
  logic [15:0] f_dur;
  logic [15:0] f_per;
  lsch_pkg::lsch_timing_t f_tim;

  // field extraction, every two-byte field LSB first
  assign len   = cmd_buf_r[0];
  assign code  = cmd_buf_r[1];
  assign f_dur = {cmd_buf_r[3], cmd_buf_r[2]};
  assign f_per = {cmd_buf_r[5], cmd_buf_r[4]};
  assign f_tim = {cmd_buf_r[9], cmd_buf_r[8], cmd_buf_r[7], cmd_buf_r[6],
                  cmd_buf_r[5], cmd_buf_r[4], cmd_buf_r[3], cmd_buf_r[2]};

  // command validation
  always_comb begin
    cmd_ok = 1'b0;
    if (code == lsch_pkg::CODE_BOND) begin
      // bonding while linked or unconfigured is answered with an error
      cmd_ok = (len == lsch_pkg::LEN_BOND) && cfg_done_r && !linked_r
            && (f_dur >= lsch_pkg::DUR_MIN) && (f_dur <= lsch_pkg::DUR_MAX)
            && (f_per >= lsch_pkg::PER_MIN) && (f_per <= lsch_pkg::PER_MAX);
    end else if (code == lsch_pkg::CODE_TERM) begin
      cmd_ok = (len == lsch_pkg::LEN_TERM) && linked_r
            && ((cmd_buf_r[2] == lsch_pkg::RSN_USER)
             || (cmd_buf_r[2] == lsch_pkg::RSN_TIME));
    end else if (code == lsch_pkg::CODE_UPD) begin
      cmd_ok = linked_r && ((len == lsch_pkg::LEN_UPD_DEF)
            || ((len == lsch_pkg::LEN_UPD_FULL)
             && (f_tim.min >= lsch_pkg::INTV_MIN) && (f_tim.max <= lsch_pkg::INTV_MAX)
             && (f_tim.min <= f_tim.max)
             && (f_tim.lat <= lsch_pkg::LAT_MAX)
             && (f_tim.tmo >= lsch_pkg::TO_MIN) && (f_tim.tmo <= lsch_pkg::TO_MAX)));
    end
  end

  // sequencer: decides the next event for the single slot
  always_comb begin
    state_nxt  = state_r;
    push       = 1'b0;
    push_type  = lsch_pkg::EV_NONE;
    push_stat  = lsch_pkg::ST_OK;
    pend_clr   = 5'h00;
    start_bond = 1'b0;
    start_term = 1'b0;
    start_upd  = 1'b0;
    unique case (state_r)
      lsch_pkg::S_IDLE: begin
        if (exec_r) begin
          push      = 1'b1;
          push_type = lsch_pkg::EV_ACK;
          push_stat = cmd_ok ? lsch_pkg::ST_OK : lsch_pkg::ST_ERR;
          if (cmd_ok) begin
            pend_clr = 5'h1F;
            if (code == lsch_pkg::CODE_BOND) begin
              start_bond = 1'b1;
              state_nxt  = lsch_pkg::S_BOND;
            end else if (code == lsch_pkg::CODE_TERM) begin
              start_term = 1'b1;
              state_nxt  = lsch_pkg::S_TERM;
            end else begin
              start_upd = 1'b1;
              state_nxt = lsch_pkg::S_TIMING;
            end
          end
        end
      end
      lsch_pkg::S_BOND: begin
        if (!evt_valid_r) begin
          if (pend_r[lsch_pkg::P_UP]) begin
            push      = 1'b1;
            push_type = lsch_pkg::EV_UP;
            pend_clr[lsch_pkg::P_UP] = 1'b1;
            state_nxt = lsch_pkg::S_PAIR;
          end else if (pend_r[lsch_pkg::P_LOST] || pend_r[lsch_pkg::P_ADVTO]) begin
            push      = 1'b1;
            push_type = lsch_pkg::EV_DOWN;
            pend_clr  = 5'h1F;
            state_nxt = lsch_pkg::S_IDLE;
          end
        end
      end
      lsch_pkg::S_PAIR: begin
        if (!evt_valid_r) begin
          if (pend_r[lsch_pkg::P_BOND]) begin
            push      = 1'b1;
            push_type = lsch_pkg::EV_PAIR;
            pend_clr[lsch_pkg::P_BOND] = 1'b1;
            state_nxt = lsch_pkg::S_IDLE;
          end else if (pend_r[lsch_pkg::P_LOST]) begin
            push      = 1'b1;
            push_type = lsch_pkg::EV_DOWN;
            pend_clr  = 5'h1F;
            state_nxt = lsch_pkg::S_IDLE;
          end
        end
      end
      lsch_pkg::S_TERM: begin
        if (!evt_valid_r && pend_r[lsch_pkg::P_LOST]) begin
          push      = 1'b1;
          push_type = lsch_pkg::EV_DOWN;
          pend_clr  = 5'h1F;
          state_nxt = lsch_pkg::S_IDLE;
        end
      end
      lsch_pkg::S_TIMING: begin
        if (!evt_valid_r && pend_r[lsch_pkg::P_TIM]) begin
          push      = 1'b1;
          push_type = lsch_pkg::EV_TIMING;
          pend_clr[lsch_pkg::P_TIM] = 1'b1;
          state_nxt = lsch_pkg::S_IDLE;
        end else if (!evt_valid_r && pend_r[lsch_pkg::P_LOST]) begin
          push      = 1'b1;
          push_type = lsch_pkg::EV_DOWN;
          pend_clr  = 5'h1F;
          state_nxt = lsch_pkg::S_IDLE;
        end
      end
      default: state_nxt = lsch_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= lsch_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // radio events held until sequenced; a new event beats its own clear
  assign pend_set = {tmr_expire, rf_timing_rpt, rf_bond_ok, rf_link_lost, rf_link_up};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 5'h00;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      linked_r <= 1'b0;
    end else if (rf_link_lost) begin
      linked_r <= 1'b0;
    end else if (rf_link_up) begin
      linked_r <= 1'b1;
    end
  end

  // event slot: loaded only while empty, popped by an apb read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_valid_r <= 1'b0;
      evt_type_r  <= lsch_pkg::EV_NONE;
      evt_code_r  <= 8'h00;
      evt_stat_r  <= 8'h00;
    end else if (push) begin
      evt_valid_r <= 1'b1;
      evt_type_r  <= push_type;
      evt_code_r  <= code;
      evt_stat_r  <= push_stat;
    end else if (acc && !pready && !pwrite && (paddr == lsch_pkg::OFF_EVT)) begin
      // pop on the edge that captures prdata, so a push during the access is kept
      evt_valid_r <= 1'b0;
    end
  end

  // advertising duration timer, counted in whole seconds
  assign tmr_expire = adv_en && (prescale_r == CYC_PER_SEC - 1) && (secs_r == 5'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= 32'h0000_0000;
      secs_r     <= 5'h00;
    end else if (start_bond) begin
      prescale_r <= 32'h0000_0000;
      secs_r     <= f_dur[4:0];
    end else if (adv_en) begin
      if (prescale_r == CYC_PER_SEC - 1) begin
        prescale_r <= 32'h0000_0000;
        secs_r     <= secs_r - 5'h01;
      end else begin
        prescale_r <= prescale_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_en     <= 1'b0;
      adv_period <= 16'h0000;
    end else if (start_bond) begin
      adv_en     <= 1'b1;
      adv_period <= f_per;
    end else if (tmr_expire || rf_link_up || rf_link_lost) begin
      adv_en     <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_req    <= 1'b0;
      term_reason <= 8'h00;
    end else begin
      term_req <= start_term;
      if (start_term) begin
        term_reason <= cmd_buf_r[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_req <= 1'b0;
      upd_prm <= '0;
    end else begin
      upd_req <= start_upd;
      if (start_upd) begin
        upd_prm <= (len == lsch_pkg::LEN_UPD_FULL) ? f_tim : cfg_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_r <= '0;
    end else if (rf_timing_rpt) begin
      rpt_r <= rf_timing;
    end
  end

  // apb: one wait state so prdata and pslverr come from flops
  assign acc    = psel && penable;
  assign do_x   = acc && pready;
  assign wr_cmd = do_x && pwrite && (paddr == lsch_pkg::OFF_CMD) && !pslverr;
  // command bytes are refused while a command or its events are in flight
  assign cmd_refuse = (state_r != lsch_pkg::S_IDLE) || evt_valid_r || exec_r
                   || ((idx_r == 4'h0)
                    && ((pwdata[7:0] == 8'h00) || (pwdata[7:0] > lsch_pkg::LEN_MAX)));

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      lsch_pkg::OFF_CMD:       begin
        rd_mux = {28'h000_0000, idx_r};
        rd_err = pwrite && cmd_refuse;
      end
      lsch_pkg::OFF_EVT:       rd_mux = {evt_valid_r, 4'h0, evt_type_r, evt_code_r,
                                         8'h00, evt_stat_r};
      lsch_pkg::OFF_CFG_INTV:  rd_mux = cfg_r[31:0];
      lsch_pkg::OFF_CFG_LATTO: rd_mux = cfg_r[63:32];
      lsch_pkg::OFF_CTRL:      rd_mux = {31'h0000_0000, cfg_done_r};
      lsch_pkg::OFF_STATUS:    rd_mux = {24'h00_0000, 2'h0, linked_r, adv_en, 1'b0, state_r};
      lsch_pkg::OFF_RPT_INTV:  rd_mux = rpt_r[31:0];
      lsch_pkg::OFF_RPT_LATTO: rd_mux = rpt_r[63:32];
      default:                 rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && rd_err;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r      <= lsch_pkg::CFG_RST;
      cfg_done_r <= 1'b0;
    end else if (do_x && pwrite) begin
      if (paddr == lsch_pkg::OFF_CFG_INTV) begin
        cfg_r[31:0] <= pwdata;
      end
      if (paddr == lsch_pkg::OFF_CFG_LATTO) begin
        cfg_r[63:32] <= pwdata;
      end
      if (paddr == lsch_pkg::OFF_CTRL) begin
        cfg_done_r <= pwdata[0];
      end
    end
  end

  // command byte assembly: length byte first, done when length bytes follow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r  <= 4'h0;
      exec_r <= 1'b0;
      for (int i = 0; i < 10; i++) begin
        cmd_buf_r[i] <= 8'h00;
      end
    end else begin
      exec_r <= 1'b0;
      if (wr_cmd) begin
        cmd_buf_r[idx_r] <= pwdata[7:0];
        if ((idx_r != 4'h0) && (idx_r == len[3:0])) begin
          idx_r  <= 4'h0;
          exec_r <= 1'b1;
        end else begin
          idx_r <= idx_r + 4'h1;
        end
      end
    end
  end

  property p_bond_ok;
    @(posedge pclk) disable iff (!presetn)
    (exec_r && state_r == lsch_pkg::S_IDLE && cmd_ok && code == lsch_pkg::CODE_BOND)
    |=> (evt_type_r == lsch_pkg::EV_ACK) && (evt_code_r == 8'h10) && adv_en
        && (state_r == lsch_pkg::S_BOND);
  endproperty
  a_bond_ok: assert property (p_bond_ok) else $error("bonding not started");

  property p_dur_range;
    @(posedge pclk) disable iff (!presetn)
    (exec_r && state_r == lsch_pkg::S_IDLE && code == lsch_pkg::CODE_BOND
     && (f_dur == 16'h0000 || f_dur > 16'h001E))
    |=> (evt_stat_r == lsch_pkg::ST_ERR) && !adv_en;
  endproperty
  a_dur_range: assert property (p_dur_range) else $error("bad duration accepted");

  property p_expire;
    @(posedge pclk) disable iff (!presetn)
    tmr_expire |=> !adv_en ##1 (state_r != lsch_pkg::S_BOND || pend_r[lsch_pkg::P_ADVTO]);
  endproperty
  a_expire: assert property (p_expire) else $error("advertising outlived duration");

  property p_per_range;
    @(posedge pclk) disable iff (!presetn)
    (exec_r && state_r == lsch_pkg::S_IDLE && code == lsch_pkg::CODE_BOND
     && (f_per < 16'h0020 || f_per > 16'h4000))
    |=> evt_stat_r == lsch_pkg::ST_ERR;
  endproperty
  a_per_range: assert property (p_per_range) else $error("bad period accepted");

  property p_up_first;
    @(posedge pclk) disable iff (!presetn)
    (state_r == lsch_pkg::S_BOND) ##1 (state_r == lsch_pkg::S_PAIR)
    |-> evt_valid_r && (evt_type_r == lsch_pkg::EV_UP);
  endproperty
  a_up_first: assert property (p_up_first) else $error("link up not reported");

  property p_fail_down;
    @(posedge pclk) disable iff (!presetn)
    (state_r == lsch_pkg::S_BOND && !evt_valid_r && !pend_r[lsch_pkg::P_UP]
     && (pend_r[lsch_pkg::P_LOST] || pend_r[lsch_pkg::P_ADVTO]))
    |=> (evt_type_r == lsch_pkg::EV_DOWN) && (state_r == lsch_pkg::S_IDLE);
  endproperty
  a_fail_down: assert property (p_fail_down) else $error("link down missing");

  property p_reason;
    @(posedge pclk) disable iff (!presetn)
    (exec_r && state_r == lsch_pkg::S_IDLE && code == lsch_pkg::CODE_TERM
     && cmd_buf_r[2] != 8'h01 && cmd_buf_r[2] != 8'h02)
    |=> (evt_stat_r == lsch_pkg::ST_ERR) && !term_req;
  endproperty
  a_reason: assert property (p_reason) else $error("bad reason accepted");

  property p_upd_len;
    @(posedge pclk) disable iff (!presetn)
    (exec_r && state_r == lsch_pkg::S_IDLE && code == lsch_pkg::CODE_UPD
     && len != 8'h01 && len != 8'h09)
    |=> (evt_stat_r == lsch_pkg::ST_ERR) && !upd_req;
  endproperty
  a_upd_len: assert property (p_upd_len) else $error("bad update length accepted");

  property p_upd_def;
    @(posedge pclk) disable iff (!presetn)
    (start_upd && len == 8'h01) |=> upd_req && (upd_prm == $past(cfg_r));
  endproperty
  a_upd_def: assert property (p_upd_def) else $error("defaults not requested");

  property p_upd_full;
    @(posedge pclk) disable iff (!presetn)
    (start_upd && len == 8'h09)
    |=> upd_req && (upd_prm.min == $past(f_dur)) && (upd_prm.tmo == $past(f_tim.tmo));
  endproperty
  a_upd_full: assert property (p_upd_full) else $error("supplied timing lost");

endmodule : lsch_link_setup_cmd
`default_nettype wire

// ---- lsch_radio_model.sv ----
// lsch_radio_model: behavioural radio link layer facing the command handler.
// assumes it shares pclk with the handler; the bench chooses whether a peer links.
`timescale 1ns/1ns
`default_nettype none
module lsch_radio_model (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // bench control
  input  wire logic                   accept,
  // requests from the handler
  input  wire logic                   adv_en,
  input  wire logic                   term_req,
  input  wire logic                   upd_req,
  input  wire lsch_pkg::lsch_timing_t upd_prm,
  // radio events to the handler
  output logic                        rf_link_up,
  output logic                        rf_link_lost,
  output logic                        rf_bond_ok,
  output logic                        rf_timing_rpt,
  output lsch_pkg::lsch_timing_t      rf_timing
);
  logic [3:0] t_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_r           <= 4'h0;
      rf_link_up    <= 1'b0;
      rf_bond_ok    <= 1'b0;
      rf_link_lost  <= 1'b0;
      rf_timing_rpt <= 1'b0;
      rf_timing     <= '0;
    end else begin
      // peer links, then pairs, only when the bench lets it
      t_r           <= (accept && (adv_en || t_r != 4'h0) && t_r != 4'h8) ? t_r + 4'h1 : 4'h0;
      rf_link_up    <= t_r == 4'h3;
      rf_bond_ok    <= t_r == 4'h7;
      rf_link_lost  <= term_req;
      rf_timing_rpt <= upd_req;
      // report field is only valid with its pulse, so it toggles otherwise
      rf_timing     <= upd_req ? upd_prm : ~rf_timing;
    end
  end
endmodule : lsch_radio_model
`default_nettype wire

// ---- test_link_setup_command_handler.sv ----
// test_link_setup_command_handler: self-checking bench of the command handler.
// assumes three-cycle APB access (one wait state) and a one second count shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module test_link_setup_command_handler;
  logic                   pclk    = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic                   accept  = 1'b0;
  logic [7:0]             paddr   = 8'h00;
  logic [31:0]            pwdata  = 32'h0000_0000;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, er, adv_en, term_req, upd_req;
  logic                   rf_link_up, rf_link_lost, rf_bond_ok, rf_timing_rpt;
  logic [15:0]            adv_period;
  logic [7:0]             term_reason;
  lsch_pkg::lsch_timing_t rf_timing, upd_prm;
  logic [7:0]             msg[$];
  int                     n_fail = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  always #20 pclk = ~pclk;
  lsch_link_setup_cmd #(.CYC_PER_SEC(10)) i_lsch_link_setup_cmd (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rf_link_up(rf_link_up),
    .rf_link_lost(rf_link_lost), .rf_bond_ok(rf_bond_ok), .rf_timing_rpt(rf_timing_rpt),
    .rf_timing(rf_timing), .adv_en(adv_en), .adv_period(adv_period), .term_req(term_req),
    .term_reason(term_reason), .upd_req(upd_req), .upd_prm(upd_prm));
  lsch_radio_model i_lsch_radio_model (.pclk(pclk), .presetn(presetn), .accept(accept),
    .adv_en(adv_en), .term_req(term_req), .upd_req(upd_req), .upd_prm(upd_prm),
    .rf_link_up(rf_link_up), .rf_link_lost(rf_link_lost), .rf_bond_ok(rf_bond_ok),
    .rf_timing_rpt(rf_timing_rpt), .rf_timing(rf_timing));
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task send;
    foreach (msg[i]) begin
      apb(1'b1, lsch_pkg::OFF_CMD, {24'h00_0000, msg[i]});
      chk("cmd byte refused", 1'b0, er);
    end
  endtask : send
  // polls the event slot; full compares the echoed code and status too
  task evt(input logic [2:0] t, input logic [7:0] c, input logic [7:0] s, input bit full);
    for (int i = 0; i < 100 && rd[31] !== 1'b1; i++) apb(1'b0, lsch_pkg::OFF_EVT, 32'h0);
    chk("event", {1'b1, t, full ? {c, s} : 16'h0000},
        {rd[31], rd[26:24], full ? {rd[23:16], rd[7:0]} : 16'h0000});
    rd = 32'h0000_0000;
  endtask : evt
  task ack(input logic [7:0] c, input logic [7:0] s);
    evt(lsch_pkg::EV_ACK, c, s, 1'b1);
  endtask : ack
  task bond_bad;
    apb(1'b1, lsch_pkg::OFF_CMD, 32'h0000_0000);
    chk("zero length refused", 1'b1, er);
    msg = '{8'h05, 8'h10, 8'h1F, 8'h00, 8'h20, 8'h00};
    send;
    ack(lsch_pkg::CODE_BOND, lsch_pkg::ST_ERR);
    msg = '{8'h05, 8'h10, 8'h01, 8'h00, 8'h1F, 8'h00};
    send;
    ack(lsch_pkg::CODE_BOND, lsch_pkg::ST_ERR);
  endtask : bond_bad
  task bond_timeout;
    accept <= 1'b0;
    msg = '{8'h05, 8'h10, 8'h01, 8'h00, 8'h20, 8'h00};
    send;
    ack(lsch_pkg::CODE_BOND, lsch_pkg::ST_OK);
    chk("advertising on", 1'b1, adv_en);
    evt(lsch_pkg::EV_DOWN, 8'h00, 8'h00, 1'b0);
    chk("advertising off", 1'b0, adv_en);
  endtask : bond_timeout
  task bond_ok;
    accept <= 1'b1;
    msg = '{8'h05, 8'h10, 8'h1E, 8'h00, 8'h00, 8'h40};
    send;
    ack(lsch_pkg::CODE_BOND, lsch_pkg::ST_OK);
    evt(lsch_pkg::EV_UP, 8'h00, 8'h00, 1'b0);
    chk("period", 16'h4000, adv_period);
    evt(lsch_pkg::EV_PAIR, 8'h00, 8'h00, 1'b0);
    accept <= 1'b0;
  endtask : bond_ok
  task upd_default;
    msg = '{8'h01, 8'h13};
    send;
    ack(lsch_pkg::CODE_UPD, lsch_pkg::ST_OK);
    evt(lsch_pkg::EV_TIMING, 8'h00, 8'h00, 1'b0);
    chk("default params", lsch_pkg::CFG_RST, upd_prm);
    apb(1'b0, lsch_pkg::OFF_RPT_LATTO, 32'h0);
    chk("report", 32'h0190_0000, rd);
  endtask : upd_default
  task upd_full;
    msg = '{8'h09, 8'h13, 8'h06, 8'h00, 8'h80, 8'h0C, 8'hE8, 8'h03, 8'h0A, 8'h00};
    send;
    ack(lsch_pkg::CODE_UPD, lsch_pkg::ST_OK);
    evt(lsch_pkg::EV_TIMING, 8'h00, 8'h00, 1'b0);
    chk("given params", 64'h000A_03E8_0C80_0006, upd_prm);
    apb(1'b0, lsch_pkg::OFF_RPT_INTV, 32'h0);
    chk("report interval", 32'h0C80_0006, rd);
    msg = '{8'h09, 8'h13, 8'h06, 8'h00, 8'h80, 8'h0C, 8'hE9, 8'h03, 8'h0A, 8'h00};
    send;
    ack(lsch_pkg::CODE_UPD, lsch_pkg::ST_ERR);
    msg = '{8'h05, 8'h13, 8'h06, 8'h00, 8'h80, 8'h0C};
    send;
    ack(lsch_pkg::CODE_UPD, lsch_pkg::ST_ERR);
  endtask : upd_full
  task term(input logic [7:0] r);
    msg = '{8'h02, 8'h11, 8'h03};
    send;
    ack(lsch_pkg::CODE_TERM, lsch_pkg::ST_ERR);
    msg = '{8'h02, 8'h11, r};
    send;
    ack(lsch_pkg::CODE_TERM, lsch_pkg::ST_OK);
    chk("reason", r, term_reason);
    evt(lsch_pkg::EV_DOWN, 8'h00, 8'h00, 1'b0);
  endtask : term
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lsch_pkg::OFF_CFG_INTV, 32'h0);
    chk("cfg reset", 32'h0028_0018, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 1'b1, er);
    msg = '{8'h05, 8'h10, 8'h01, 8'h00, 8'h20, 8'h00};
    send;
    ack(lsch_pkg::CODE_BOND, lsch_pkg::ST_ERR);
    chk("advertising before config", 1'b0, adv_en);
    apb(1'b1, lsch_pkg::OFF_CTRL, 32'h0000_0001);
    bond_bad;
    bond_timeout;
    bond_ok;
    upd_default;
    upd_full;
    term(lsch_pkg::RSN_USER);
    bond_ok;
    term(lsch_pkg::RSN_TIME);
    give_verdict;
  end
endmodule : test_link_setup_command_handler
`default_nettype wire
